/* core/charger_cfg_dev.sv */
// charger device end: alarm/control registers, alarms, protection trips
// assumes measurements come from on-chip logic on pclk; analog levels are asynchronous
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module charger_cfg_dev
	import charger_cfg_pkg::*;
#(
	parameter int CUR_W = CUR_WIDTH
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register port
	charger_cfg_if.dev link,
	// measurements, signed mA
	input wire logic signed [CUR_W-1:0] battery_current,
	input wire logic signed [CUR_W-1:0] input_current,
	// analog state
	input wire logic soft_start_done,
	input wire logic bus_voltage_error_high,
	// power stage
	output logic bypass_on,
	output logic switching_on,
	output logic charge_enable
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [DATA_W-1:0] bat_oc_r;
	logic [DATA_W-1:0] bat_uc_r;
	logic [DATA_W-1:0] ctrl_r;
	logic chg_r;
	logic [EV_W-1:0] flags_r;
	logic [EV_W-1:0] flags_nxt;
	logic ack_r;
	logic [DATA_W-1:0] rdata_r;
	logic ss_meta_r;
	logic ss_r;
	logic err_meta_r;
	logic err_r;
	logic int_n_r;
	logic bypass_r;
	logic switching_r;

	wire logic access;
	wire logic wr;
	wire logic rd;
	wire logic wr_oc;
	wire logic wr_uc;
	wire logic wr_ctrl;
	wire logic wr_chg;
	wire logic rd_flags;
	wire logic reg_reset;
	wire logic oc_reached;
	wire logic uc_reached;
	wire logic oc_alarm;
	wire logic uc_alarm;
	wire logic in_uc;
	wire logic in_uc_evt;
	wire logic rev_evt;
	wire logic trip;
	wire logic [EV_W-1:0] live;
	wire logic [EV_W-1:0] events;
	wire logic [DATA_W-1:0] rd_mux;
	wire logic switch_allowed;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = a == off;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// register port decode
	// one access per request; ack pulse drops it so a held request is not repeated
	assign access = link.req & ~ack_r;
	assign wr = access & link.we;
	assign rd = access & ~link.we;
	assign wr_oc = wr & hit(link.addr, OFF_BAT_OC_ALARM);
	assign wr_uc = wr & hit(link.addr, OFF_BAT_UC_ALARM);
	assign wr_ctrl = wr & hit(link.addr, OFF_CTRL_FIRST);
	assign wr_chg = wr & hit(link.addr, OFF_CHARGE_CTRL);
	assign rd_flags = rd & hit(link.addr, OFF_EVENT_FLAGS);
	assign reg_reset = wr_chg & link.wdata[REG_RST_BIT];

	assign rd_mux = hit(link.addr, OFF_BAT_OC_ALARM) ? bat_oc_r :
		hit(link.addr, OFF_BAT_UC_ALARM) ? bat_uc_r :
		hit(link.addr, OFF_CTRL_FIRST) ? ctrl_r :
		hit(link.addr, OFF_LIVE_STATUS) ? {{(DATA_W-EV_W){1'b0}}, live} :
		hit(link.addr, OFF_EVENT_FLAGS) ? {{(DATA_W-EV_W){1'b0}}, flags_r} :
		hit(link.addr, OFF_CHARGE_CTRL) ? {{(DATA_W-1){1'b0}}, chg_r} :
		{DATA_W{1'b0}};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_r <= 1'b0;
			rdata_r <= '0;
		end else begin
			ack_r <= access;
			if (rd) begin
				rdata_r <= rd_mux;
			end
		end
	end

	assign link.ack = ack_r;
	assign link.rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bat_oc_r <= RST_BAT_OC_ALARM;
			bat_uc_r <= RST_BAT_UC_ALARM;
			ctrl_r <= RST_CTRL_FIRST;
		end else if (reg_reset) begin
			bat_oc_r <= RST_BAT_OC_ALARM;
			bat_uc_r <= RST_BAT_UC_ALARM;
			ctrl_r <= RST_CTRL_FIRST;
		end else begin
			if (wr_oc) begin
				bat_oc_r <= link.wdata;
			end
			if (wr_uc) begin
				bat_uc_r <= link.wdata;
			end
			if (wr_ctrl) begin
				ctrl_r <= link.wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// asynchronous analog levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ss_meta_r <= 1'b0;
			ss_r <= 1'b0;
			err_meta_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			ss_meta_r <= soft_start_done;
			ss_r <= ss_meta_r;
			err_meta_r <= bus_voltage_error_high;
			err_r <= err_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// alarm thresholds
	alarm_threshold_cmp #(
		.CUR_W(CUR_W),
		.STEP_MA(BAT_OC_STEP_MA),
		.OFFSET_MA(BAT_OC_OFFSET_MA)
	) oc_cmp (
		.code(bat_oc_r[CODE_MSB:0]),
		.meas(battery_current),
		.reached(oc_reached)
	);

	alarm_threshold_cmp #(
		.CUR_W(CUR_W),
		.STEP_MA(BAT_UC_STEP_MA),
		.OFFSET_MA(BAT_UC_OFFSET_MA)
	) uc_cmp (
		.code(bat_uc_r[CODE_MSB:0]),
		.meas(battery_current),
		.reached(uc_reached)
	);

	assign oc_alarm = oc_reached & ~bat_oc_r[ALARM_OFF_BIT];
	assign uc_alarm = ~uc_reached & ~bat_uc_r[ALARM_OFF_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// input protections
	// undercurrent setting bit at 0 is the reserved code: protection never fires; reverse never fires with its setting bit at 1
	assign in_uc = ss_r & ctrl_r[UCP_SET_BIT] & (int'(input_current) < IN_UC_MA);
	assign in_uc_evt = in_uc;
	// reverse current shows as negative input current
	assign rev_evt = chg_r & ~ctrl_r[RCP_OFF_BIT] & ~ctrl_r[RCP_SET_BIT] &
		(int'(input_current) < -REV_MA);
	assign trip = (in_uc_evt & ~ctrl_r[UCP_OFF_BIT]) | rev_evt;

	assign live = {rev_evt, in_uc, uc_alarm, oc_alarm};
	assign events = live;

	////////////////////////////////////////////////////////////////////////////////
	// event flags, cleared by reading; a new event beats the clear
	assign flags_nxt = (rd_flags ? {EV_W{1'b0}} : flags_r) | events;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= '0;
			int_n_r <= 1'b1;
		end else begin
			flags_r <= flags_nxt;
			int_n_r <= ~|flags_nxt;
		end
	end

	assign link.int_n = int_n_r;

	////////////////////////////////////////////////////////////////////////////////
	// charge enable and power stage
	// trip beats a host write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chg_r <= 1'b0;
		end else if (trip) begin
			chg_r <= 1'b0;
		end else if (wr_chg & ~reg_reset) begin
			chg_r <= link.wdata[CHARGE_ENABLE_BIT];
		end
	end

	assign switch_allowed = ~err_r | ctrl_r[ERRHI_OFF_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bypass_r <= 1'b0;
			switching_r <= 1'b0;
		end else begin
			bypass_r <= chg_r & ~trip;
			switching_r <= chg_r & ~trip & switch_allowed;
		end
	end

	assign bypass_on = bypass_r;
	assign switching_on = switching_r;
	assign charge_enable = chg_r;

endmodule

/* core/charger_cfg_pkg.sv */
// constants shared by both ends of the charger configuration link
// assumes one clock domain (pclk) for the whole design
package charger_cfg_pkg;

	// register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int CUR_WIDTH = 16;

	// device register offsets
	localparam logic [7:0] OFF_BAT_OC_ALARM = 8'h03;
	localparam logic [7:0] OFF_BAT_UC_ALARM = 8'h04;
	localparam logic [7:0] OFF_CTRL_FIRST = 8'h05;
	localparam logic [7:0] OFF_LIVE_STATUS = 8'h0C;
	localparam logic [7:0] OFF_EVENT_FLAGS = 8'h0D;
	localparam logic [7:0] OFF_CHARGE_CTRL = 8'h0E;

	// reset values
	localparam logic [7:0] RST_BAT_OC_ALARM = 8'h46;
	localparam logic [7:0] RST_BAT_UC_ALARM = 8'h28;
	localparam logic [7:0] RST_CTRL_FIRST = 8'h02;

	// field positions
	localparam int ALARM_OFF_BIT = 7;
	localparam int CODE_MSB = 6;
	localparam int UCP_OFF_BIT = 7;
	localparam int UCP_SET_BIT = 6;
	localparam int RCP_OFF_BIT = 5;
	localparam int RCP_SET_BIT = 4;
	localparam int CFG_BIT = 3;
	localparam int ERRHI_OFF_BIT = 2;
	localparam int CHARGE_ENABLE_BIT = 0;
	localparam int REG_RST_BIT = 7;

	// event flag / status bits
	localparam int EV_BAT_OC = 0;
	localparam int EV_BAT_UC = 1;
	localparam int EV_IN_UC = 2;
	localparam int EV_REV = 3;
	localparam int EV_W = 4;

	// thresholds in mA
	localparam int BAT_OC_STEP_MA = 100;
	localparam int BAT_OC_OFFSET_MA = 0;
	localparam int BAT_UC_STEP_MA = 50;
	localparam int BAT_UC_OFFSET_MA = 0;
	localparam int IN_UC_MA = 250;
	localparam int REV_MA = 300;

	// host APB register offsets
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_RESULT = 8'h04;
	localparam logic [7:0] APB_IRQ_STATUS = 8'h08;
	localparam logic [7:0] APB_IRQ_MASK = 8'h0C;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_WRITE_BIT = 16;
	localparam int RES_BUSY_BIT = 8;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_DEV = 1;
	localparam int IRQ_REFUSED = 2;
	localparam int IRQ_W = 3;

	typedef enum logic [0:0] {
		LINK_IDLE = 1'b0,
		LINK_BUSY = 1'b1
	} link_state_t;

endpackage

/* core/charger_cfg_if.sv */
// register port joining host controller and charger device
// assumes both ends run on the same pclk
`timescale 1ns/10ps
interface charger_cfg_if;
	import charger_cfg_pkg::*;
	logic req;
	logic we;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic ack;
	logic int_n;

	modport dev(input req, input we, input addr, input wdata, output rdata, output ack, output int_n);
	modport host(output req, output we, output addr, output wdata, input rdata, input ack, input int_n);
endinterface

/* core/alarm_threshold_cmp.sv */
// code-to-threshold conversion and compare for one current alarm
// assumes measured current is a signed mA value on pclk
`timescale 1ns/10ps
module alarm_threshold_cmp #(
	parameter int CUR_W = 16,
	parameter int STEP_MA = 100,
	parameter int OFFSET_MA = 0
) (
	// setting
	input wire logic [6:0] code,
	// measurement
	input wire logic signed [CUR_W-1:0] meas,
	// result
	output logic reached
);
	wire logic signed [31:0] thr_ma;
	wire logic signed [31:0] meas_ma;

	// int keeps the product clear of overflow for any 7-bit code
	assign thr_ma = int'(code) * STEP_MA + OFFSET_MA;
	assign meas_ma = int'(meas);
	assign reached = meas_ma >= thr_ma;
endmodule

/* core/charger_cfg_host.sv */
// host controller end: APB command registers driving the device register port
// assumes APB master and device on the same pclk
`timescale 1ns/10ps
module charger_cfg_host
	import charger_cfg_pkg::*;
#(
	parameter logic [6:0] OC_ALARM_MAX_CODE = 7'h46
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// register port
	charger_cfg_if.host link
);

	////////////////////////////////////////////////////////////////////////////////
	link_state_t state_r;
	logic req_r;
	logic we_r;
	logic [ADDR_W-1:0] addr_r;
	logic [DATA_W-1:0] wdata_r;
	logic [DATA_W-1:0] result_r;
	logic [IRQ_W-1:0] status_r;
	logic [IRQ_W-1:0] mask_r;
	logic ctrl_ok_r;
	logic int_n_d_r;
	logic [31:0] prdata_r;

	wire logic apb_wr;
	wire logic apb_rd;
	wire logic go;
	wire logic cmd_we;
	wire logic [ADDR_W-1:0] cmd_addr;
	wire logic [DATA_W-1:0] cmd_data;
	wire logic to_ctrl;
	wire logic to_oc;
	wire logic chg_on;
	wire logic refuse;
	wire logic start;
	wire logic done;
	wire logic dev_evt;
	wire logic [DATA_W-1:0] fixed_data;
	wire logic [IRQ_W-1:0] events;
	wire logic [31:0] rd_mux;

	////////////////////////////////////////////////////////////////////////////////
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & penable & ~pwrite;
	assign go = apb_wr & (paddr == APB_CMD);
	assign cmd_we = pwdata[CMD_WRITE_BIT];
	assign cmd_addr = pwdata[CMD_ADDR_LSB +: ADDR_W];
	assign cmd_data = pwdata[DATA_W-1:0];
	assign to_ctrl = cmd_we & (cmd_addr == OFF_CTRL_FIRST);
	assign to_oc = cmd_we & (cmd_addr == OFF_BAT_OC_ALARM);
	assign chg_on = cmd_we & (cmd_addr == OFF_CHARGE_CTRL) & cmd_data[CHARGE_ENABLE_BIT];
	function automatic logic ctrl_okay();
		ctrl_okay = ctrl_ok_r;
	endfunction

	// no enable until a control write has armed the protections
	assign refuse = go & ((state_r == LINK_BUSY) | (chg_on & ~ctrl_okay()));
	assign start = go & ~refuse;

	// control writes always arm undercurrent, clear the reverse setting bit, set config; other bits pass through
	assign fixed_data = to_ctrl ?
		((cmd_data | (8'h01 << UCP_SET_BIT) | (8'h01 << CFG_BIT)) & ~(8'h01 << RCP_SET_BIT)) :
		(to_oc && cmd_data[CODE_MSB:0] > OC_ALARM_MAX_CODE) ?
		{cmd_data[ALARM_OFF_BIT], OC_ALARM_MAX_CODE} : cmd_data;

	////////////////////////////////////////////////////////////////////////////////
	assign done = (state_r == LINK_BUSY) & link.ack;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= LINK_IDLE;
			req_r <= 1'b0;
			we_r <= 1'b0;
			addr_r <= '0;
			wdata_r <= '0;
			result_r <= '0;
			ctrl_ok_r <= 1'b0;
		end else begin
			case (state_r)
				LINK_IDLE: begin
					if (start) begin
						state_r <= LINK_BUSY;
						req_r <= 1'b1;
						we_r <= cmd_we;
						addr_r <= cmd_addr;
						wdata_r <= fixed_data;
						if (to_ctrl) begin
							ctrl_ok_r <= 1'b1;
						end
					end
				end
				LINK_BUSY: begin
					if (link.ack) begin
						state_r <= LINK_IDLE;
						req_r <= 1'b0;
						result_r <= link.rdata;
					end
				end
				default: begin
					state_r <= LINK_IDLE;
					req_r <= 1'b0;
				end
			endcase
		end
	end

	assign link.req = req_r;
	assign link.we = we_r;
	assign link.addr = addr_r;
	assign link.wdata = wdata_r;

	////////////////////////////////////////////////////////////////////////////////
	// device alarms reach software here so it can watch the current
	assign dev_evt = int_n_d_r & ~link.int_n;
	assign events = {refuse, dev_evt, done};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_n_d_r <= 1'b1;
			status_r <= '0;
			mask_r <= '0;
		end else begin
			int_n_d_r <= link.int_n;
			// set beats the read clear
			status_r <= ((apb_rd & (paddr == APB_IRQ_STATUS)) ? {IRQ_W{1'b0}} : status_r) | events;
			if (apb_wr & (paddr == APB_IRQ_MASK)) begin
				mask_r <= pwdata[IRQ_W-1:0];
			end
		end
	end

	assign irq = |(status_r & mask_r);

	////////////////////////////////////////////////////////////////////////////////
	assign rd_mux = (paddr == APB_CMD) ? {15'h0000, we_r, addr_r, wdata_r} :
		(paddr == APB_RESULT) ? {23'h000000, state_r == LINK_BUSY, result_r} :
		(paddr == APB_IRQ_STATUS) ? {29'h00000000, status_r} :
		(paddr == APB_IRQ_MASK) ? {29'h00000000, mask_r} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
		end else if (psel & ~penable & ~pwrite) begin
			prdata_r <= rd_mux;
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

endmodule

/* bench/charger_cfg_props.sv */
// concurrent checks on the register port between host and device ends
// assumes instantiation beside the interface, one pclk domain
`timescale 1ns/10ps
module charger_cfg_props
	import charger_cfg_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link
	input wire logic req,
	input wire logic we,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic ack,
	input wire logic int_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
////////////////////////////////////////
	ack_on_time_a: assert property (req && !ack |=> ack)
		else $error("ack not one cycle after request");
	ack_pulse_a: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (ack |-> $past(req))
		else $error("ack without request");
	req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
		else $error("request changed before ack");
	req_drop_a: assert property (ack |=> !req)
		else $error("request kept after ack");
	reset_idle_a: assert property ($rose(presetn) |-> int_n && !req && !ack && rdata == 8'h00)
		else $error("link not idle after reset");
	rdata_hold_a: assert property (!$stable(rdata) |-> ack && !we)
		else $error("read data moved outside a read");
	int_release_a: assert property ($rose(int_n) |-> !$past(we) && $past(addr) == OFF_EVENT_FLAGS)
		else $error("interrupt released without flag read");
	addr_load_a: assert property (!$stable(addr) |-> $rose(req))
		else $error("address moved outside a request");
////////////////////////////////////////
	cover property (ack && !we && addr == OFF_EVENT_FLAGS);
	cover property ($fell(int_n));
	cover property (ack && we && addr == OFF_CHARGE_CTRL);
endmodule

/* bench/test_charger_current_alarm_regs.sv */
// self-checking bench: apb master on the host end, device measurements driven directly
// assumes one 50 MHz pclk; read results and pin states checked from a queue of notes
`timescale 1ns/10ps
module test_charger_current_alarm_regs;
	import charger_cfg_pkg::*;
	typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} note_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin_chk = 0;
	logic soft_start_done = 0, bus_err = 0, oo, uo;
	logic [7:0] paddr = 8'h00, d;
	logic [31:0] pwdata = 32'h0, prdata, got;
	logic pready, pslverr, irq, bypass_on, switching_on, charge_enable;
	logic signed [15:0] battery_current = 16'sh03E8, input_current = 16'sh03E8;
	note_t notes[$];
	note_t n;
	bit ctrl_seen = 0;
	int mismatches = 0, samples_checked = 0, seed = 32'h97E3A073, c, u, bc;
	charger_cfg_if link_if();
	charger_cfg_dev u_charger_cfg_dev (.pclk(pclk), .presetn(presetn), .link(link_if),
		.battery_current(battery_current), .input_current(input_current), .soft_start_done(soft_start_done),
		.bus_voltage_error_high(bus_err), .bypass_on(bypass_on), .switching_on(switching_on),
		.charge_enable(charge_enable));
	charger_cfg_host u_charger_cfg_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .link(link_if));
	charger_cfg_props u_charger_cfg_props (.pclk(pclk), .presetn(presetn), .req(link_if.req), .we(link_if.we),
		.addr(link_if.addr), .wdata(link_if.wdata), .rdata(link_if.rdata), .ack(link_if.ack), .int_n(link_if.int_n));
	always #10 pclk = ~pclk;
////////////////////////////////////////
	// checker side: oldest note against each finished read or pin sample
	always @(posedge pclk) begin
		if ((psel && penable && pready && !pwrite) || pin_chk) begin
			n = notes.pop_front();
			got = pin_chk ? {27'h0, pslverr, irq, charge_enable, bypass_on, switching_on} : prdata;
			samples_checked++;
			if ((got & n.mask) !== (n.exp & n.mask)) begin
				mismatches++;
				$display("[ERR] %s expected %h seen %h", n.name, n.exp & n.mask, got & n.mask);
			end
		end
	end
	task final_report;
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{nm, e, m});
		apb(0, a, 32'h0);
	endtask
	// refused commands never ack, so only their wait is capped; others wait for the watchdog
	task dev(input logic w, input logic [7:0] a, input logic [7:0] v);
		int k;
		bit no_ack;
		no_ack = w && a == OFF_CHARGE_CTRL && v[CHARGE_ENABLE_BIT] && !ctrl_seen;
		ctrl_seen = ctrl_seen || (w && a == OFF_CTRL_FIRST);
		apb(1, APB_CMD, {15'h0, w, a, v});
		k = 0;
		while (link_if.ack !== 1'b1 && (!no_ack || k < 20)) begin
			@(posedge pclk);
			k++;
		end
		repeat (2) @(posedge pclk);
	endtask
	task drd(input string nm, input logic [7:0] a, input logic [7:0] e);
		dev(0, a, 8'h00);
		rd(nm, APB_RESULT, {24'h0, e}, 32'h1FF);
	endtask
	task pins(input string nm, input logic [3:0] e);
		repeat (3) @(posedge pclk);
		notes.push_back('{nm, {28'h0, e}, 32'h1F});
		pin_chk <= 1;
		@(posedge pclk);
		pin_chk <= 0;
	endtask
	initial begin
		#400000;
		mismatches++;
		final_report();
	end
////////////////////////////////////////
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		drd("oc_alarm", OFF_BAT_OC_ALARM, RST_BAT_OC_ALARM);
		drd("uc_alarm", OFF_BAT_UC_ALARM, RST_BAT_UC_ALARM);
		drd("ctrl", OFF_CTRL_FIRST, RST_CTRL_FIRST);
		drd("dev_unmapped", 8'h20, 8'h00);
		rd("apb_unmapped", 8'h10, 32'h0, 32'hFFFFFFFF);
		dev(1, OFF_CHARGE_CTRL, 8'h01);
		rd("refused", APB_IRQ_STATUS, 32'h4, 32'h4);
		rd("refused_clr", APB_IRQ_STATUS, 32'h0, 32'h4);
		pins("no_charge", 4'h0);
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			dev(1, OFF_CTRL_FIRST, d);
			drd("ctrl_rw", OFF_CTRL_FIRST, (d | 8'h48) & 8'hEF);
		end
		dev(1, OFF_BAT_OC_ALARM, 8'hFF);
		drd("oc_clamp", OFF_BAT_OC_ALARM, 8'hC6);
		// threshold boundary, one below and exactly at code times step
		for (int i = 0; i < 8; i++) begin
			c = 1 + {$random(seed)} % 70;
			u = 1 + {$random(seed)} % 127;
			oo = (i % 4 == 3);
			uo = (i % 4 == 2);
			bc = c * 100 - i % 2;
			battery_current <= bc[15:0];
			dev(1, OFF_BAT_OC_ALARM, {oo, c[6:0]});
			dev(1, OFF_BAT_UC_ALARM, {uo, u[6:0]});
			drd("live", OFF_LIVE_STATUS, {6'h0, !uo && bc < u * 50, !oo && bc >= c * 100});
		end
		dev(1, OFF_BAT_OC_ALARM, 8'h80);
		dev(1, OFF_BAT_UC_ALARM, 8'h80);
		dev(0, OFF_EVENT_FLAGS, 8'h00);
		drd("flags_idle", OFF_EVENT_FLAGS, 8'h00);
		apb(1, APB_IRQ_MASK, 32'h2);
		rd("irq_clr", APB_IRQ_STATUS, 32'h1, 32'h5);
		battery_current <= 16'sh01F4;
		dev(1, OFF_BAT_OC_ALARM, 8'h01);
		pins("irq_on", 4'h8);
		drd("flags_oc", OFF_EVENT_FLAGS, 8'h01);
		apb(1, APB_IRQ_MASK, 32'h0);
		pins("irq_masked", 4'h0);
		rd("irq_sticky", APB_IRQ_STATUS, 32'h2, 32'h2);
		dev(1, OFF_BAT_OC_ALARM, 8'h80);
		dev(1, OFF_CTRL_FIRST, 8'h00);
		dev(1, OFF_CHARGE_CTRL, 8'h01);
		pins("charging", 4'h7);
		bus_err <= 1;
		pins("err_hi", 4'h6);
		dev(1, OFF_CTRL_FIRST, 8'h04);
		pins("err_hi_off", 4'h7);
		bus_err <= 0;
		input_current <= 16'sh0064;
		pins("pre_soft_start", 4'h7);
		dev(1, OFF_CTRL_FIRST, 8'h80);
		soft_start_done <= 1;
		pins("ucp_off", 4'h7);
		drd("ucp_seen", OFF_LIVE_STATUS, 8'h04);
		dev(1, OFF_CTRL_FIRST, 8'h00);
		pins("ucp_trip", 4'h0);
		drd("ucp_flag", OFF_EVENT_FLAGS, 8'h05);
		soft_start_done <= 0;
		input_current <= 16'shFED4;
		dev(1, OFF_CHARGE_CTRL, 8'h01);
		pins("rev_edge", 4'h7);
		input_current <= 16'shFED3;
		pins("rev_trip", 4'h0);
		dev(1, OFF_CHARGE_CTRL, 8'h80);
		drd("rst_ctrl", OFF_CTRL_FIRST, RST_CTRL_FIRST);
		drd("rst_oc", OFF_BAT_OC_ALARM, RST_BAT_OC_ALARM);
		final_report();
	end
endmodule
